/* shared/aifr_pkg.sv */
// Constants, codes and helpers for the analog input function router
package aifr_pkg;
    // Converter samples: ten bits, 1024 steps
    localparam int ADC_W = 10;
    localparam int ADC_MAX = 32'h0000_03ff;
    // 4 mA on a 0..20 mA converter span is 1/5 of full scale
    localparam int CUR_ZERO = 32'h0000_00cd;
    localparam int CUR_SPAN = ADC_MAX - CUR_ZERO;
    // Levels in 0.1 percent steps, signed
    localparam int PCT_W = 16;
    localparam int PCT_FULL = 32'h0000_03e8;
    localparam int PCT_POS = 32'h0000_7fff;
    localparam int PCT_NEG = -32'sh0000_8000;
    localparam logic [PCT_W-1:0] GAIN_DEF = 16'h03e8;
    localparam logic [PCT_W-1:0] BIAS_DEF = 16'h0000;
    // Filter time constant in 0.01 s units, applied once per tick
    localparam int TC_W = 8;
    localparam logic [TC_W-1:0] TC_DEF = 8'h1e;
    localparam logic [TC_W-1:0] TC_MAX = 8'hc8;
    localparam int FRAC_W = 6;
    localparam int FILT_W = ADC_W + FRAC_W;
    // Clock and filter tick
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // Second input function codes
    localparam logic [7:0] FN_BIAS = 8'h00;
    localparam logic [7:0] FN_AUX = 8'h02;
    localparam logic [7:0] FN_PI_FB = 8'h0b;
    localparam logic [7:0] FN_BIAS2 = 8'h0d;
    localparam logic [7:0] FN_MOTOR_TEMP = 8'h0e;
    localparam logic [7:0] FN_PI_DIFF = 8'h16;
    localparam logic [7:0] FN_NOT_USED = 8'h1f;
    // Signal level and master selects
    localparam logic [1:0] LVL_VOLT = 2'h0;
    localparam logic [1:0] LVL_CUR = 2'h2;
    localparam logic MSEL_SECOND = 1'h1;
    localparam logic [1:0] RESP_OFF = 2'h0;
    localparam int TH_DLY_W = 12;

    // Thermal detection state
    typedef enum logic [1:0] {
        AIFR_TH_NORMAL = 2'b00,
        AIFR_TH_PENDING = 2'b01,
        AIFR_TH_TRIPPED = 2'b10
    } aifr_th_state_t;

    // Saturate a wide sum into a level word
    function automatic logic signed [PCT_W-1:0] aifr_sat(input logic signed [31:0] v);
        logic signed [31:0] r;
        r = v;
        if (v > PCT_POS) r = PCT_POS;
        if (v < PCT_NEG) r = PCT_NEG;
        return r[PCT_W-1:0];
    endfunction
endpackage

/* hdl/aifr_scale.sv */
// Level conversion and gain/bias scaling of one filtered analog input
`timescale 1ns/1ps
`default_nettype none
module aifr_scale
    import aifr_pkg::*;
(
    input wire logic [ADC_W-1:0] sample,
    input wire logic current_span,
    input wire logic [PCT_W-1:0] gain,
    input wire logic signed [PCT_W-1:0] bias,
    output logic signed [PCT_W-1:0] level_pct,
    output logic signed [PCT_W-1:0] scaled_pct
);
    logic signed [31:0] smp;
    logic signed [31:0] lvl;
    logic signed [31:0] prod;

    // Percent of full scale; below 4 mA reads as zero rather than negative
    always_comb begin
        smp = signed'({22'h000000, sample});
        if (current_span) begin
            lvl = (smp - CUR_ZERO) * PCT_FULL / CUR_SPAN; // RL20
        end else begin
            lvl = smp * PCT_FULL / ADC_MAX; // RL4
        end
        if (lvl < 0) begin
            lvl = 0;
        end
        level_pct = lvl[PCT_W-1:0];
        // Gain then bias, saturating instead of wrapping
        prod = lvl * signed'({16'h0000, gain}) / PCT_FULL + 32'(bias); // RL8 RL22
        scaled_pct = aifr_sat(prod);
    end
endmodule
`default_nettype wire

/* hdl/aifr_router.sv */
// Filter, scaling and function routing of the two analog inputs
// Functional notes
// RL1: Frequency bias adds second level to first
// RL2: First gain/bias applied before adding second
// RL3: Parameter bias and frequency bias sum
// RL4: Monitors show levels in percent full scale
// RL5: Aux with master select one uses second
// RL6: Aux and multi-step ref closed use second
// RL7: PI feedback function routes second as feedback
// RL8: Second input has own gain and bias
// RL9: Frequency bias 2 acts as frequency bias
// RL10: Motor temperature compares alarm/fault with delay
// RL11: PI differential uses first as other feedback
// RL12: Setpoint sign sets second below/above first
// RL13: Differential mode: first on PI, second on two
// RL14: PI feedback monitor shows feedback level
// RL15: Not used ignores second input
// RL16: Shared first-order filter, 0..2.00 s constant
// RL17: Terminal source: master select picks input
// RL18: Not aux: first input always master
// RL19: Samples are ten-bit, 1024 steps
// RL20: Second input voltage or current span
// RL21: Speed command clamped to 0..max frequency
// RL22: Fixed point 0.1 percent, saturating sums
`timescale 1ns/1ps
`default_nettype none
module aifr_router
    import aifr_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [ADC_W-1:0] first_analog_input,
    input wire logic [ADC_W-1:0] second_analog_input,
    input wire logic [7:0] second_input_function_select,
    input wire logic master_reference_select,
    input wire logic terminal_speed_source,
    input wire logic multi_step_ref1_closed,
    input wire logic [1:0] second_input_signal_level,
    input wire logic [PCT_W-1:0] first_input_gain,
    input wire logic signed [PCT_W-1:0] first_input_bias,
    input wire logic [PCT_W-1:0] second_input_gain,
    input wire logic signed [PCT_W-1:0] second_input_bias,
    input wire logic [TC_W-1:0] input_filter_time_constant,
    input wire logic signed [PCT_W-1:0] max_frequency_pct,
    input wire logic signed [PCT_W-1:0] pi_differential_setpoint,
    input wire logic signed [PCT_W-1:0] thermal_alarm_level,
    input wire logic signed [PCT_W-1:0] thermal_fault_level,
    input wire logic [1:0] thermal_alarm_response,
    input wire logic [1:0] thermal_fault_response,
    input wire logic [TH_DLY_W-1:0] thermal_sense_delay,
    output logic signed [PCT_W-1:0] speed_command,
    output logic speed_from_second,
    output logic signed [PCT_W-1:0] first_input_level_monitor,
    output logic signed [PCT_W-1:0] second_input_level_monitor,
    output logic signed [PCT_W-1:0] pi_feedback_monitor,
    output logic signed [PCT_W-1:0] pi_feedback_two_monitor,
    output logic pi_feedback_valid,
    output logic signed [PCT_W-1:0] pi_differential_error,
    output logic [1:0] thermal_alarm,
    output logic [1:0] thermal_fault
);
    localparam int TCW = (TICK_CYCLES_P > 2) ? $clog2(TICK_CYCLES_P) : 1;
    localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES_P - 1);

    logic [TCW-1:0] tick_q, tick_d;
    logic tick;
    logic [FILT_W-1:0] filt_q [2];
    logic [FILT_W-1:0] filt_d [2];
    logic [ADC_W-1:0] raw [2];
    logic signed [PCT_W-1:0] lvl [2];
    logic signed [PCT_W-1:0] scl [2];
    logic [TC_W-1:0] tc;
    logic is_bias, is_aux, is_pi_fb, is_diff, is_temp, use_second;
    logic signed [31:0] cmd_raw;
    logic signed [PCT_W-1:0] cmd_clamped;
    logic signed [PCT_W-1:0] speed_d, mon1_d, mon2_d, pifb_d, pifb2_d, perr_d;
    logic sfs_d, pival_d;

    assign raw[0] = first_analog_input;
    assign raw[1] = second_analog_input;

    // Filter tick divider; long count so a bench can shorten it
    always_comb begin
        tick = (tick_q == TICK_LAST);
        tick_d = tick ? '0 : tick_q + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tick_q <= '0;
        end else if (ce) begin
            tick_q <= tick_d;
        end
    end

    // First-order lag: y += (x - y) * T / (tau + T), T being one tick
    always_comb begin
        logic signed [FILT_W+1:0] diff;
        diff = '0;
        tc = (input_filter_time_constant > TC_MAX) ? TC_MAX : input_filter_time_constant;
        for (int i = 0; i < 2; i++) begin
            diff = signed'({2'b00, raw[i], FRAC_W'(0)}) - signed'({2'b00, filt_q[i]});
            filt_d[i] = filt_q[i];
            if (tick) begin
                filt_d[i] = FILT_W'(signed'({2'b00, filt_q[i]})
                    + diff / signed'({2'b00, 8'(tc) + 8'h01})); // RL16
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            filt_q[0] <= '0;
            filt_q[1] <= '0;
        end else if (ce) begin
            filt_q[0] <= filt_d[0];
            filt_q[1] <= filt_d[1];
        end
    end

    // First input is a voltage span; second follows its level select
    aifr_scale u_scale_first (
        .sample(filt_q[0][FILT_W-1:FRAC_W]), // RL19
        .current_span(1'b0),
        .gain(first_input_gain),
        .bias(first_input_bias),
        .level_pct(lvl[0]),
        .scaled_pct(scl[0])
    );

    aifr_scale u_scale_second (
        .sample(filt_q[1][FILT_W-1:FRAC_W]),
        .current_span(second_input_signal_level == LVL_CUR), // RL20
        .gain(second_input_gain),
        .bias(second_input_bias),
        .level_pct(lvl[1]),
        .scaled_pct(scl[1])
    );

    // Function decode and speed command selection
    always_comb begin
        is_bias = (second_input_function_select == FN_BIAS)
            || (second_input_function_select == FN_BIAS2); // RL9
        is_aux = (second_input_function_select == FN_AUX);
        is_pi_fb = (second_input_function_select == FN_PI_FB);
        is_diff = (second_input_function_select == FN_PI_DIFF);
        is_temp = (second_input_function_select == FN_MOTOR_TEMP);
        // Second input only wins as a configured aux reference
        use_second = is_aux && ((terminal_speed_source
            && master_reference_select == MSEL_SECOND) // RL5 RL17
            || multi_step_ref1_closed); // RL6 RL18
        if (use_second) begin
            cmd_raw = 32'(scl[1]);
        end else if (is_bias) begin
            cmd_raw = 32'(scl[0]) + 32'(scl[1]); // RL1 RL2 RL3
        end else begin
            cmd_raw = 32'(scl[0]); // RL15
        end
        cmd_clamped = aifr_sat(cmd_raw); // RL22
        if (cmd_clamped < 0) begin
            cmd_clamped = '0; // RL21
        end else if (cmd_clamped > max_frequency_pct) begin
            cmd_clamped = max_frequency_pct;
        end
        speed_d = cmd_clamped;
        sfs_d = use_second;
        mon1_d = lvl[0]; // RL4
        mon2_d = lvl[1];
        pival_d = is_pi_fb || is_diff;
        pifb_d = is_diff ? scl[0] : (is_pi_fb ? scl[1] : '0); // RL7 RL11 RL13 RL14
        pifb2_d = is_diff ? scl[1] : '0;
        // Error positive when second sits below first plus setpoint
        perr_d = is_diff ? aifr_sat(32'(pi_differential_setpoint)
            - (32'(scl[1]) - 32'(scl[0]))) : '0; // RL12
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            speed_command <= '0;
            speed_from_second <= 1'b0;
            first_input_level_monitor <= '0;
            second_input_level_monitor <= '0;
            pi_feedback_monitor <= '0;
            pi_feedback_two_monitor <= '0;
            pi_feedback_valid <= 1'b0;
            pi_differential_error <= '0;
        end else if (ce) begin
            speed_command <= speed_d;
            speed_from_second <= sfs_d;
            first_input_level_monitor <= mon1_d;
            second_input_level_monitor <= mon2_d;
            pi_feedback_monitor <= pifb_d;
            pi_feedback_two_monitor <= pifb2_d;
            pi_feedback_valid <= pival_d;
            pi_differential_error <= perr_d;
        end
    end

    // Thermal detection: index 0 alarm, 1 fault; outputs carry response code
    aifr_th_state_t th_q [2];
    aifr_th_state_t th_d [2];
    logic [TH_DLY_W-1:0] thc_q [2];
    logic [TH_DLY_W-1:0] thc_d [2];
    logic hot [2];
    logic [1:0] resp [2];
    logic [1:0] tho_d [2];

    assign resp[0] = thermal_alarm_response;
    assign resp[1] = thermal_fault_response;

    always_comb begin
        for (int t = 0; t < 2; t++) begin
            hot[t] = is_temp && resp[t] != RESP_OFF
                && scl[1] >= (t == 0 ? thermal_alarm_level : thermal_fault_level); // RL10
            th_d[t] = th_q[t];
            thc_d[t] = thc_q[t];
            unique case (th_q[t])
                AIFR_TH_NORMAL: begin
                    thc_d[t] = '0;
                    if (hot[t]) th_d[t] = AIFR_TH_PENDING;
                end
                AIFR_TH_PENDING: begin
                    if (!hot[t]) begin
                        th_d[t] = AIFR_TH_NORMAL;
                    end else if (thc_q[t] >= thermal_sense_delay) begin
                        th_d[t] = AIFR_TH_TRIPPED; // RL10
                    end else if (tick) begin
                        thc_d[t] = thc_q[t] + 1'b1;
                    end
                end
                AIFR_TH_TRIPPED: begin
                    if (!hot[t]) th_d[t] = AIFR_TH_NORMAL;
                end
                default: th_d[t] = AIFR_TH_NORMAL;
            endcase
            tho_d[t] = (th_d[t] == AIFR_TH_TRIPPED) ? resp[t] : 2'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            th_q[0] <= AIFR_TH_NORMAL;
            th_q[1] <= AIFR_TH_NORMAL;
            thc_q[0] <= '0;
            thc_q[1] <= '0;
            thermal_alarm <= 2'h0;
            thermal_fault <= 2'h0;
        end else if (ce) begin
            th_q[0] <= th_d[0];
            th_q[1] <= th_d[1];
            thc_q[0] <= thc_d[0];
            thc_q[1] <= thc_d[1];
            thermal_alarm <= tho_d[0];
            thermal_fault <= tho_d[1];
        end
    end

    // Checks on routing, clamping, filter and thermal sequencing
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic bias_in_range;
    assign bias_in_range = (cmd_raw >= 0) && (cmd_raw <= 32'(max_frequency_pct));

    property p_bias_sum;
        ce && is_bias && !use_second && bias_in_range
            |=> speed_command == $past(scl[0]) + $past(scl[1]);
    endproperty
    a_bias_sum: assert property (p_bias_sum) else $error("bias sum wrong"); // RL1

    property p_bias2;
        ce && second_input_function_select == FN_BIAS2 |=> !speed_from_second;
    endproperty
    a_bias2: assert property (p_bias2) else $error("bias 2 misrouted"); // RL9

    property p_master_second;
        ce && is_aux && terminal_speed_source && master_reference_select == MSEL_SECOND
            |=> speed_from_second;
    endproperty
    a_master_second: assert property (p_master_second) else $error("aux master lost"); // RL5

    property p_not_aux;
        ce && !is_aux |=> !speed_from_second;
    endproperty
    a_not_aux: assert property (p_not_aux) else $error("second used while not aux"); // RL18

    property p_clamp;
        speed_command >= 0 && (speed_command <= max_frequency_pct || $changed(max_frequency_pct));
    endproperty
    a_clamp: assert property (p_clamp) else $error("speed out of range"); // RL21

    property p_diff_mon;
        ce && is_diff |=> pi_feedback_monitor == $past(scl[0])
            && pi_feedback_two_monitor == $past(scl[1]) && pi_feedback_valid;
    endproperty
    a_diff_mon: assert property (p_diff_mon) else $error("differential monitors wrong"); // RL13

    property p_pi_fb;
        ce && is_pi_fb |=> pi_feedback_monitor == $past(scl[1]) && pi_feedback_valid;
    endproperty
    a_pi_fb: assert property (p_pi_fb) else $error("PI feedback not second"); // RL7

    property p_not_used;
        ce && second_input_function_select == FN_NOT_USED && scl[0] >= 0
            && scl[0] <= max_frequency_pct |=> speed_command == $past(scl[0]);
    endproperty
    a_not_used: assert property (p_not_used) else $error("unused input leaked"); // RL15

    property p_filter_pass;
        ce && tick && input_filter_time_constant == 8'h00
            |=> filt_q[0][FILT_W-1:FRAC_W] == $past(first_analog_input);
    endproperty
    a_filter_pass: assert property (p_filter_pass) else $error("zero constant not passed"); // RL16

    sequence s_th_pending;
        th_q[0] == AIFR_TH_PENDING && thc_q[0] >= thermal_sense_delay && ce;
    endsequence
    sequence s_th_raise;
        th_q[0] == AIFR_TH_TRIPPED ##0 thermal_alarm == $past(thermal_alarm_response);
    endsequence
    property p_th_alarm;
        (s_th_pending and hot[0]) |=> s_th_raise;
    endproperty
    a_th_alarm: assert property (p_th_alarm) else $error("thermal alarm not raised"); // RL10
endmodule
`default_nettype wire

/* verif/aifr_adc_model.sv */
// Converter model delivering ten-bit samples to the router
`timescale 1ns/1ps
`default_nettype none
module aifr_adc_model
    import aifr_pkg::*;
(
    input wire logic clk,
    input wire logic slow,
    input wire logic [ADC_W-1:0] first_target,
    input wire logic [ADC_W-1:0] second_target,
    output logic [ADC_W-1:0] first_sample,
    output logic [ADC_W-1:0] second_sample
);
    logic [ADC_W-1:0] first_hold;
    logic [ADC_W-1:0] second_hold;
    // Slow mode adds a conversion stage, as a busy converter would
    always_ff @(posedge clk) begin
        first_hold <= first_target;
        second_hold <= second_target;
        first_sample <= slow ? first_hold : first_target;
        second_sample <= slow ? second_hold : second_target;
    end
endmodule
`default_nettype wire

/* verif/tb_aifr_router.sv */
// Self-checking bench for the analog input function router
`timescale 1ns/1ps
`default_nettype none
module tb_aifr_router;
    import aifr_pkg::*;
    localparam int TICKS = 4;
    localparam logic [7:0] FNS [7] = '{FN_BIAS, FN_AUX, FN_PI_FB, FN_BIAS2,
                                      FN_MOTOR_TEMP, FN_PI_DIFF, FN_NOT_USED};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic slow = 1'b0;
    logic [ADC_W-1:0] t1 = 10'h3ff;
    logic [ADC_W-1:0] t2 = 10'h000;
    logic [ADC_W-1:0] a1;
    logic [ADC_W-1:0] a2;
    logic [7:0] fsel = FN_BIAS;
    logic msel = 1'b0;
    logic tsrc = 1'b0;
    logic ms1 = 1'b0;
    logic [1:0] lsel = LVL_VOLT;
    logic [15:0] g1 = 16'h03e8;
    logic [15:0] b1 = 16'h0000;
    logic [15:0] g2 = 16'h03e8;
    logic [15:0] b2 = 16'h0000;
    logic [7:0] tc = 8'h03;
    logic [15:0] maxf = 16'h03e8;
    logic [15:0] sp = 16'h0000;
    logic [15:0] alv = 16'h012c;
    logic [15:0] flv = 16'h0258;
    logic [1:0] ares = 2'h1;
    logic [1:0] fres = 2'h2;
    logic [11:0] dly = 12'h002;
    logic [15:0] spd, m1, m2, pf, pf2, perr;
    logic sfs, pv;
    logic [1:0] ta, tf;
    int err_count = 0;
    int n_tests = 0;

    // Clock: 40 ns period
    always #20 clk = ~clk;

    aifr_adc_model i_aifr_adc_model (.clk(clk), .slow(slow), .first_target(t1),
        .second_target(t2), .first_sample(a1), .second_sample(a2));

    aifr_router #(.TICK_CYCLES_P(TICKS)) i_aifr_router (.clk(clk), .reset_n(reset_n),
        .ce(ce), .first_analog_input(a1), .second_analog_input(a2),
        .second_input_function_select(fsel), .master_reference_select(msel),
        .terminal_speed_source(tsrc), .multi_step_ref1_closed(ms1),
        .second_input_signal_level(lsel), .first_input_gain(g1), .first_input_bias(b1),
        .second_input_gain(g2), .second_input_bias(b2), .input_filter_time_constant(tc),
        .max_frequency_pct(maxf), .pi_differential_setpoint(sp),
        .thermal_alarm_level(alv), .thermal_fault_level(flv),
        .thermal_alarm_response(ares), .thermal_fault_response(fres),
        .thermal_sense_delay(dly), .speed_command(spd), .speed_from_second(sfs),
        .first_input_level_monitor(m1), .second_input_level_monitor(m2),
        .pi_feedback_monitor(pf), .pi_feedback_two_monitor(pf2),
        .pi_feedback_valid(pv), .pi_differential_error(perr),
        .thermal_alarm(ta), .thermal_fault(tf));

    function automatic int sat(int v);
        return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
    endfunction

    // Current span starts at a fifth of the converter range
    function automatic int lvl(int x, bit cur);
        if (!cur) return x * 1000 / 1023;
        return x < 205 ? 0 : (x - 205) * 1000 / 818;
    endfunction

    function automatic int scl(int l, int g, int b);
        return sat(l * g / 1000 + b);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Reference model of every output from the current inputs
    task automatic check_all();
        int l1, l2, s1, s2, e, use2;
        bit hot_a, hot_f, bias;
        l1 = lvl(t1, 1'b0);
        l2 = lvl(t2, lsel == LVL_CUR);
        s1 = scl(l1, g1, $signed(b1));
        s2 = scl(l2, g2, $signed(b2));
        bias = (fsel == FN_BIAS || fsel == FN_BIAS2);
        use2 = (fsel == FN_AUX) && ((tsrc && msel) || ms1);
        e = bias ? sat(s1 + s2) : (use2 ? s2 : s1);
        e = e < 0 ? 0 : (e > $signed(maxf) ? $signed(maxf) : e);
        check(m1, l1[15:0]);
        if (fsel != FN_NOT_USED) check(m2, l2[15:0]);
        check(spd, e[15:0]);
        if (!bias) check(16'(sfs), 16'(use2));
        check(pf, fsel == FN_PI_FB ? s2[15:0] : (fsel == FN_PI_DIFF ? s1[15:0] : 16'h0));
        check(pf2, fsel == FN_PI_DIFF ? s2[15:0] : 16'h0);
        check(16'(pv), 16'(fsel == FN_PI_FB || fsel == FN_PI_DIFF));
        e = sat($signed(sp) - (s2 - s1));
        check(perr, fsel == FN_PI_DIFF ? e[15:0] : 16'h0);
        hot_a = fsel == FN_MOTOR_TEMP && s2 >= $signed(alv) && ares != RESP_OFF;
        hot_f = fsel == FN_MOTOR_TEMP && s2 >= $signed(flv) && fres != RESP_OFF;
        check(16'(ta), 16'(hot_a ? ares : 2'h0));
        check(16'(tf), 16'(hot_f ? fres : 2'h0));
    endtask

    task automatic drive_random(input logic [7:0] f, input int k);
        fsel <= f;
        slow <= 1'($urandom_range(0, 1));
        t1 <= k == 0 ? 10'h000 : 10'($urandom_range(0, 1023));
        t2 <= k == 1 ? 10'h3ff : 10'($urandom_range(0, 1023));
        msel <= 1'($urandom_range(0, 1));
        tsrc <= 1'($urandom_range(0, 1));
        ms1 <= 1'($urandom_range(0, 1));
        lsel <= 2'($urandom_range(0, 2));
        g1 <= 16'($urandom_range(0, 10000));
        g2 <= 16'($urandom_range(0, 10000));
        b1 <= 16'($urandom_range(0, 2000) - 1000);
        b2 <= 16'($urandom_range(0, 2000) - 1000);
        sp <= 16'($urandom_range(0, 2000) - 1000);
        ares <= 2'($urandom_range(0, 3));
        fres <= 2'($urandom_range(0, 3));
    endtask

    initial begin
        int held_q[$];
        void'($urandom(45));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1 check(spd, 16'h0);
        check(m1, 16'h0);
        // Slow filter: two ticks in, level is on its way but short of full
        repeat (2 * TICKS + 1) @(posedge clk);
        #1 check(16'(m1 > 0 && m1 < 16'h03e8), 16'h1);
        @(posedge clk);
        tc <= 8'h00;
        for (int f = 0; f < 7; f++) begin
            for (int k = 0; k < 6; k++) begin
                drive_random(FNS[f], k);
                repeat (6 * TICKS) @(posedge clk);
                #1 check_all();
                @(posedge clk);
            end
        end
        // Clock enable low must hold the first level monitor
        held_q.push_back(lvl(t1, 1'b0));
        ce <= 1'b0;
        t1 <= ~t1;
        repeat (3 * TICKS) @(posedge clk);
        #1 check(m1, 16'(held_q.pop_front()));
        @(posedge clk);
        ce <= 1'b1;
        repeat (6 * TICKS) @(posedge clk);
        #1 check_all();
        // Mid-run reset clears outputs; bias zeroed so the restart is quiet
        @(posedge clk);
        reset_n <= 1'b0;
        b1 <= 16'h0000;
        repeat (2) @(posedge clk);
        #1 check(spd, 16'h0);
        check(m1, 16'h0);
        check(pf, 16'h0);
        check(16'(ta), 16'h0);
        @(posedge clk);
        reset_n <= 1'b1;
        repeat (6 * TICKS) @(posedge clk);
        #1 check_all();
        summarize();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
